/* rtl/vps_regs.svh */
// Register map, field positions and reset values of the playback sequencer
`ifndef VPS_REGS_SVH
`define VPS_REGS_SVH

`define VPS_ADDR_W        6
`define VPS_OFF_CTRL      6'h00
`define VPS_OFF_RATE      6'h04
`define VPS_OFF_START1    6'h08
`define VPS_OFF_CFG1      6'h0c
`define VPS_OFF_START2    6'h10
`define VPS_OFF_CFG2      6'h14
`define VPS_OFF_STATUS    6'h18
`define VPS_OFF_IRQ_STAT  6'h1c
`define VPS_OFF_IRQ_MASK  6'h20

`define VPS_CTRL_PLAY     0
`define VPS_CTRL_STOP     1
`define VPS_CTRL_SHUTOFF  2
`define VPS_CTRL_SEL      3
`define VPS_CTRL_REPEAT   4
`define VPS_CTRL_TOGGLE   5
`define VPS_CTRL_KEEP     6'h3c

`define VPS_CFG_FRAMES_LO 0
`define VPS_CFG_LOOPS_LO  16

`define VPS_IRQ_W         2
`define VPS_IRQ_CFG_DONE  0
`define VPS_IRQ_PLAY_END  1

`define VPS_RST_WORD      32'h0000_0000
`define VPS_RST_MASK      2'h0

`endif

/* rtl/vps_pkg.sv */
// Shared types of the playback sequencer
package vps_pkg;

  // Playback state of the sequencer
  typedef enum logic [1:0] {
    VPS_IDLE   = 2'b00,
    VPS_PLAY   = 2'b01,
    VPS_FREEZE = 2'b10,
    VPS_OFF    = 2'b11
  } vps_state_t;

  // One captured configuration set
  typedef struct packed {
    logic [31:0] start;
    logic [15:0] frames;
    logic [15:0] loops;
  } vps_cfg_t;

  // One frame fetch request to the flash reader
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] frame;
  } vps_fetch_t;

endpackage : vps_pkg

/* rtl/vps_fetch_port.sv */
// Holds one flash frame request until the flash reader accepts it
`timescale 1ns/1ns
module vps_fetch_port
  import vps_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       issue,
  input  vps_fetch_t      issue_req,
  output logic            fetch_valid,
  output vps_fetch_t      fetch_req,
  input  wire logic       fetch_ready,
  output logic            overrun
);

  logic valid_reg;

  // Request stays up until taken; a newer frame replaces a stale one
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;
    end else if (issue) begin
      valid_reg <= 1'b1;
    end else if (fetch_ready) begin
      valid_reg <= 1'b0;
    end
  end

  // Request payload
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fetch_req <= '0;
    end else if (issue) begin
      fetch_req <= issue_req;
    end
  end

  // Flags a frame replaced before the reader took it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overrun <= 1'b0;
    end else begin
      overrun <= issue & valid_reg & ~fetch_ready;
    end
  end

  assign fetch_valid = valid_reg;

endmodule : vps_fetch_port

/* rtl/vps_top.sv */
// Video playback sequencer: registers, frame timer, configuration sequencing
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`include "vps_regs.svh"
module vps_top
  import vps_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             fetch_valid,
  output vps_fetch_t       fetch_req,
  input  wire logic        fetch_ready,
  output logic             mirror_show,
  output logic             illum_en,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic        ack_reg;
  logic        wr_en;
  logic [31:0] ctrl_reg;
  logic [31:0] rate_reg;
  logic [31:0] start1_reg;
  logic [31:0] cfg1_reg;
  logic [31:0] start2_reg;
  logic [31:0] cfg2_reg;
  logic [`VPS_IRQ_W-1:0] ist_reg;
  logic [`VPS_IRQ_W-1:0] ist_next;
  logic [`VPS_IRQ_W-1:0] imask_reg;
  logic [`VPS_IRQ_W-1:0] ev_set;
  logic [`VPS_IRQ_W-1:0] ist_clr;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic        play_req;
  logic        stop_req;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // One wait cycle per access: simple and keeps read data registered
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_en           = avs_write & ack_reg;

  // Control word; play and stop act as one-shot commands and never stay stored
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg <= `VPS_RST_WORD;
    end else if (wr_en && avs_address == `VPS_OFF_CTRL) begin
      ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable) & 32'(`VPS_CTRL_KEEP);
    end
  end

  assign play_req = wr_en && avs_address == `VPS_OFF_CTRL && avs_byteenable[0] &&
                    avs_writedata[`VPS_CTRL_PLAY];
  assign stop_req = wr_en && avs_address == `VPS_OFF_CTRL && avs_byteenable[0] &&
                    avs_writedata[`VPS_CTRL_STOP];

  // Frame rate and the two configuration sets
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rate_reg   <= `VPS_RST_WORD;
      start1_reg <= `VPS_RST_WORD;
      cfg1_reg   <= `VPS_RST_WORD;
      start2_reg <= `VPS_RST_WORD;
      cfg2_reg   <= `VPS_RST_WORD;
    end else if (wr_en) begin
      case (avs_address)
        `VPS_OFF_RATE:   rate_reg   <= be_merge(rate_reg, avs_writedata, avs_byteenable);
        `VPS_OFF_START1: start1_reg <= be_merge(start1_reg, avs_writedata, avs_byteenable);
        `VPS_OFF_CFG1:   cfg1_reg   <= be_merge(cfg1_reg, avs_writedata, avs_byteenable);
        `VPS_OFF_START2: start2_reg <= be_merge(start2_reg, avs_writedata, avs_byteenable);
        `VPS_OFF_CFG2:   cfg2_reg   <= be_merge(cfg2_reg, avs_writedata, avs_byteenable);
        default:         rate_reg   <= rate_reg;
      endcase
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      imask_reg <= `VPS_RST_MASK;
    end else if (wr_en && avs_address == `VPS_OFF_IRQ_MASK && avs_byteenable[0]) begin
      imask_reg <= avs_writedata[`VPS_IRQ_W-1:0];
    end
  end

  // Sticky flags, write one to clear; a new event beats a clear
  assign ist_clr = (wr_en && avs_address == `VPS_OFF_IRQ_STAT && avs_byteenable[0]) ?
                   avs_writedata[`VPS_IRQ_W-1:0] : '0;
  assign ist_next = (ist_reg & ~ist_clr) | ev_set;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ist_reg <= '0;
    end else begin
      ist_reg <= ist_next;
    end
  end

  // Level interrupt from unmasked flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_next & imask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame timer

  logic [31:0] rate_cnt_reg;
  logic        frame_tick;

  // Zero rate stalls playback rather than spinning one frame per cycle
  assign frame_tick = (rate_reg != '0) && (rate_cnt_reg >= rate_reg - 32'h0000_0001);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rate_cnt_reg <= '0;
    end else if (frame_tick || rate_reg == '0) begin
      rate_cnt_reg <= '0;
    end else begin
      rate_cnt_reg <= rate_cnt_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  vps_state_t  state_reg;
  vps_state_t  state_next;
  vps_cfg_t    act_reg;
  vps_cfg_t    act_next;
  vps_cfg_t    cfg_a;
  vps_cfg_t    cfg_b;
  logic        set_reg;
  logic        set_next;
  logic        second_reg;
  logic        second_next;
  logic [15:0] frame_reg;
  logic [15:0] frame_next;
  logic [15:0] loop_reg;
  logic [15:0] loop_next;
  logic        pend_play_reg;
  logic        issue;
  logic        overrun;
  logic        last_frame;
  logic        last_loop;
  logic        sel_bit;

  assign cfg_a = '{start:  start1_reg,
                   frames: cfg1_reg[`VPS_CFG_FRAMES_LO +: 16],
                   loops:  cfg1_reg[`VPS_CFG_LOOPS_LO +: 16]};
  assign cfg_b = '{start:  start2_reg,
                   frames: cfg2_reg[`VPS_CFG_FRAMES_LO +: 16],
                   loops:  cfg2_reg[`VPS_CFG_LOOPS_LO +: 16]};
  assign sel_bit = ctrl_reg[`VPS_CTRL_SEL];

  // Counts of zero are treated as one, so a set can never hang
  assign last_frame = (frame_reg + 16'h0001 >= act_reg.frames);
  assign last_loop  = (loop_reg + 16'h0001 >= act_reg.loops);

  // Play request waits for the next frame boundary
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend_play_reg <= 1'b0;
    end else if (stop_req) begin
      pend_play_reg <= 1'b0;
    end else if (play_req) begin
      pend_play_reg <= 1'b1;
    end else if (frame_tick) begin
      pend_play_reg <= 1'b0;
    end
  end

  // Next-state logic; every change except a stop happens on a frame tick
  always_comb begin
    state_next  = state_reg;
    act_next    = act_reg;
    set_next    = set_reg;
    second_next = second_reg;
    frame_next  = frame_reg;
    loop_next   = loop_reg;
    issue       = 1'b0;
    ev_set      = '0;
    if (stop_req) begin
      state_next = VPS_IDLE;
    end else if (frame_tick && pend_play_reg) begin
      // Capture the selected set as it starts
      act_next    = sel_bit ? cfg_b : cfg_a;
      set_next    = sel_bit;
      second_next = 1'b0;
      frame_next  = '0;
      loop_next   = '0;
      state_next  = VPS_PLAY;
      issue       = 1'b1;
    end else if (frame_tick) begin
      case (state_reg)
        VPS_PLAY: begin
          if (!last_frame) begin
            frame_next = frame_reg + 16'h0001;
            issue      = 1'b1;
          end else if (!last_loop) begin
            frame_next = '0;
            loop_next  = loop_reg + 16'h0001;
            issue      = 1'b1;
          end else begin
            ev_set[`VPS_IRQ_CFG_DONE] = 1'b1;
            frame_next = '0;
            loop_next  = '0;
            if (ctrl_reg[`VPS_CTRL_TOGGLE] && !second_reg) begin
              // Hand over to the other set
              act_next    = set_reg ? cfg_a : cfg_b;
              set_next    = ~set_reg;
              second_next = 1'b1;
              issue       = 1'b1;
            end else if (ctrl_reg[`VPS_CTRL_REPEAT]) begin
              // No end action, start over from the selected set
              act_next    = sel_bit ? cfg_b : cfg_a;
              set_next    = sel_bit;
              second_next = 1'b0;
              issue       = 1'b1;
            end else begin
              ev_set[`VPS_IRQ_PLAY_END] = 1'b1;
              // End action picked by shutoff
              state_next = ctrl_reg[`VPS_CTRL_SHUTOFF] ? VPS_OFF : VPS_FREEZE;
            end
          end
        end
        VPS_FREEZE: state_next = VPS_FREEZE;
        VPS_OFF:    state_next = VPS_OFF;
        VPS_IDLE:   state_next = VPS_IDLE;
        default:    state_next = VPS_IDLE;
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg  <= VPS_IDLE;
      act_reg    <= '0;
      set_reg    <= 1'b0;
      second_reg <= 1'b0;
      frame_reg  <= '0;
      loop_reg   <= '0;
    end else begin
      state_reg  <= state_next;
      act_reg    <= act_next;
      set_reg    <= set_next;
      second_reg <= second_next;
      frame_reg  <= frame_next;
      loop_reg   <= loop_next;
    end
  end

  // Display drive: freeze keeps the last image lit, off and idle go dark
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mirror_show <= 1'b0;
      illum_en    <= 1'b0;
    end else begin
      mirror_show <= (state_next == VPS_PLAY) || (state_next == VPS_FREEZE);
      illum_en    <= (state_next == VPS_PLAY) || (state_next == VPS_FREEZE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash request and read-back

  vps_fetch_t issue_req;

  // Base address plus frame index; the reader walks compressed frames itself
  assign issue_req = '{addr: act_next.start, frame: frame_next};

  vps_fetch_port u_fetch (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .issue       (issue),
    .issue_req   (issue_req),
    .fetch_valid (fetch_valid),
    .fetch_req   (fetch_req),
    .fetch_ready (fetch_ready),
    .overrun     (overrun)
  );

  // Status: state, active set, second pass, overrun seen
  logic overrun_seen_reg;

  // A new overrun beats the clear by play, so no overrun goes unseen
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overrun_seen_reg <= 1'b0;
    end else if (overrun) begin
      overrun_seen_reg <= 1'b1;
    end else if (play_req) begin
      overrun_seen_reg <= 1'b0;
    end
  end

  assign status_word = {27'h0000000, overrun_seen_reg, second_reg, set_reg, state_reg};

  // Read mux; unmapped offsets read as zero
  always_comb begin
    case (avs_address)
      `VPS_OFF_CTRL:     rd_mux = ctrl_reg;
      `VPS_OFF_RATE:     rd_mux = rate_reg;
      `VPS_OFF_START1:   rd_mux = start1_reg;
      `VPS_OFF_CFG1:     rd_mux = cfg1_reg;
      `VPS_OFF_START2:   rd_mux = start2_reg;
      `VPS_OFF_CFG2:     rd_mux = cfg2_reg;
      `VPS_OFF_STATUS:   rd_mux = status_word;
      `VPS_OFF_IRQ_STAT: rd_mux = {30'h00000000, ist_reg};
      `VPS_OFF_IRQ_MASK: rd_mux = {30'h00000000, imask_reg};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle, valid when waitrequest drops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule : vps_top

/* dv/vps_top_props.sv */
// Port assertions of the playback sequencer
`timescale 1ns/1ns
`include "vps_regs.svh"
module vps_top_props
  import vps_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        fetch_valid,
  input wire vps_fetch_t  fetch_req,
  input wire logic        fetch_ready,
  input wire logic        mirror_show,
  input wire logic        illum_en,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Register write completing at this edge with the low lane on
  logic wr_ok;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  ////////////////////////////////
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state too long");
  property p_show_illum;
    mirror_show == illum_en;
  endproperty
  a_show_illum: assert property (p_show_illum) else $error("light and image differ");
  property p_fetch_hold;
    fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_req);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("frame request dropped");
  property p_fetch_drop;
    fetch_valid && fetch_ready |=> !fetch_valid;
  endproperty
  a_fetch_drop: assert property (p_fetch_drop) else $error("frame read twice");
  // A frame is only fetched for an image that is being shown
  property p_fetch_shown;
    $rose(fetch_valid) |-> ##[0:2] mirror_show;
  endproperty
  a_fetch_shown: assert property (p_fetch_shown) else $error("fetch without image");
  property p_fetch_gap;
    $rose(fetch_valid) |=> (!$rose(fetch_valid)) [*3];
  endproperty
  a_fetch_gap: assert property (p_fetch_gap) else $error("frames too close");
  property p_stop_off;
    wr_ok && avs_address == `VPS_OFF_CTRL && avs_writedata[`VPS_CTRL_STOP]
      |=> ##1 (!mirror_show) [*3];
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("image after stop");
  property p_mask_quiet;
    wr_ok && avs_address == `VPS_OFF_IRQ_MASK && avs_writedata[1:0] == 2'h0
      |=> ##1 (!irq) [*2];
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("masked irq high");
endmodule : vps_top_props

/* dv/vps_flash_model.sv */
// Flash frame reader answering frame requests promptly or slowly
`timescale 1ns/1ns
module vps_flash_model
  import vps_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic       fetch_valid,
  input  wire vps_fetch_t fetch_req,
  output logic            fetch_ready = 1'h0
);
  vps_fetch_t got_q[$];
  logic       waited = 1'h0;
  // Ready after one cycle, or two when slow; accepted reads are logged
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fetch_ready <= 1'h0;
      waited      <= 1'h0;
    end else if (fetch_valid && fetch_ready) begin
      fetch_ready <= 1'h0;
      waited      <= 1'h0;
      got_q.push_back(fetch_req);
    end else if (fetch_valid) begin
      fetch_ready <= !slow || waited;
      waited      <= 1'h1;
    end else begin
      fetch_ready <= 1'h0;
    end
  end
endmodule : vps_flash_model

/* dv/vps_top_tb_top.sv */
// Self-checking bench of the playback sequencer
`timescale 1ns/1ns
`include "vps_regs.svh"
module vps_top_tb_top
  import vps_pkg::*;
  ;
  logic        clk_sys        = 1'h0;
  logic        rst_n          = 1'h0;
  logic [5:0]  avs_address    = 6'h00;
  logic        avs_read       = 1'h0;
  logic        avs_write      = 1'h0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        slow           = 1'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic        avs_waitrequest;
  logic        fetch_valid;
  logic        fetch_ready;
  logic        mirror_show;
  logic        illum_en;
  logic        irq;
  vps_fetch_t  fetch_req;
  int          bad_count      = 0;
  int          compares       = 0;
  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;
  vps_top i_vps_top (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .fetch_valid,
    .fetch_req, .fetch_ready, .mirror_show, .illum_en, .irq);
  vps_flash_model i_vps_flash_model (.clk_sys, .rst_n, .slow, .fetch_valid,
    .fetch_req, .fetch_ready);
  ////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Avalon access held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // No cycle count assumed; a hung slave is left to the watchdog
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk($sformatf("reg_%h", a), e, rd);
  endtask : rdc
  // Next frame read taken by the flash model
  task automatic fx(input logic [31:0] a, input logic [15:0] f);
    vps_fetch_t q;
    int n;
    n = 0;
    q = 48'h0;
    while (i_vps_flash_model.got_q.size() == 0 && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    if (n < 500) begin
      q = i_vps_flash_model.got_q.pop_front();
    end
    chk("fetch_addr", a, q.addr);
    chk("fetch_frame", 32'(f), 32'(q.frame));
  endtask : fx
  // Several frame intervals in which no further read may appear
  task automatic quiet();
    repeat (32) @(posedge clk_sys);
    chk("extra_fetch", 32'h0, 32'(i_vps_flash_model.got_q.size()));
  endtask : quiet
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    rdc(`VPS_OFF_CTRL, 32'h0);
    rdc(`VPS_OFF_STATUS, 32'h0);
    rdc(`VPS_OFF_IRQ_STAT, 32'h0);
    rdc(`VPS_OFF_IRQ_MASK, 32'h0);
    wr(`VPS_OFF_CTRL, 32'hfc);
    rdc(`VPS_OFF_CTRL, 32'h3c);
    wr(`VPS_OFF_CTRL, 32'h0);
    wr(`VPS_OFF_START1, 32'h1000);
    avs_byteenable <= 4'h1;
    wr(`VPS_OFF_START1, 32'hffff_ffff);
    avs_byteenable <= 4'hf;
    rdc(`VPS_OFF_START1, 32'h10ff);
    wr(6'h3c, 32'hffff_ffff);
    rdc(6'h3c, 32'h0);
    $display("test regs done");
    // Set one, two loops of two frames, freeze at the end
    wr(`VPS_OFF_IRQ_MASK, 32'h3);
    wr(`VPS_OFF_RATE, 32'h8);
    wr(`VPS_OFF_START1, 32'h1000);
    wr(`VPS_OFF_CFG1, 32'h0002_0002);
    wr(`VPS_OFF_CTRL, 32'h01);
    fx(32'h1000, 16'h0);
    wr(`VPS_OFF_START1, 32'h1800);
    for (int i = 1; i < 4; i++) fx(32'h1000, 16'(i % 2));
    quiet();
    rdc(`VPS_OFF_STATUS, 32'h2);
    rdc(`VPS_OFF_IRQ_STAT, 32'h3);
    chk("show", 32'h1, 32'(mirror_show));
    wr(`VPS_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(negedge clk_sys);
    chk("irq_masked", 32'h0, 32'(irq));
    wr(`VPS_OFF_IRQ_STAT, 32'h1);
    wr(`VPS_OFF_IRQ_MASK, 32'h3);
    rdc(`VPS_OFF_IRQ_STAT, 32'h2);
    repeat (2) @(negedge clk_sys);
    chk("irq_set", 32'h1, 32'(irq));
    wr(`VPS_OFF_IRQ_STAT, 32'h2);
    repeat (2) @(negedge clk_sys);
    chk("irq_clear", 32'h0, 32'(irq));
    wr(`VPS_OFF_CTRL, 32'h2);
    rdc(`VPS_OFF_STATUS, 32'h0);
    chk("show_stop", 32'h0, 32'(mirror_show));
    $display("test freeze done");
    // Toggle from set two to set one with a slow flash, then turn off
    slow <= 1'h1;
    wr(`VPS_OFF_START2, 32'h2000);
    wr(`VPS_OFF_CFG2, 32'h0001_0001);
    wr(`VPS_OFF_CFG1, 32'h0001_0002);
    wr(`VPS_OFF_CTRL, 32'h2d);
    fx(32'h2000, 16'h0);
    wr(`VPS_OFF_START2, 32'h3000);
    fx(32'h1800, 16'h0);
    fx(32'h1800, 16'h1);
    quiet();
    bus(1'h0, `VPS_OFF_STATUS, 32'h0);
    chk("state_off", 32'h3, rd & 32'h3);
    rdc(`VPS_OFF_IRQ_STAT, 32'h3);
    chk("illum_off", 32'h0, 32'(illum_en));
    $display("test toggle done");
    // Endless repeat of set one, restart on set two, then stop
    slow <= 1'h0;
    wr(`VPS_OFF_IRQ_STAT, 32'h3);
    wr(`VPS_OFF_CTRL, 32'h11);
    for (int i = 0; i < 5; i++) fx(32'h1800, 16'(i % 2));
    wr(`VPS_OFF_CTRL, 32'h19);
    fx(32'h3000, 16'h0);
    fx(32'h3000, 16'h0);
    wr(`VPS_OFF_CTRL, 32'h2);
    quiet();
    bus(1'h0, `VPS_OFF_STATUS, 32'h0);
    chk("state_idle", 32'h0, rd & 32'h3);
    rdc(`VPS_OFF_IRQ_STAT, 32'h1);
    $display("test repeat done");
    // Toggle with repeat from set one, then restart on a still image that freezes
    wr(`VPS_OFF_CTRL, 32'h31);
    fx(32'h1800, 16'h0);
    fx(32'h1800, 16'h1);
    fx(32'h3000, 16'h0);
    fx(32'h1800, 16'h0);
    wr(`VPS_OFF_CTRL, 32'h09);
    fx(32'h3000, 16'h0);
    quiet();
    bus(1'h0, `VPS_OFF_STATUS, 32'h0);
    chk("state_still", 32'h2, rd & 32'h3);
    chk("show_still", 32'h1, 32'(mirror_show));
    wr(`VPS_OFF_CTRL, 32'h2);
    repeat (2) @(negedge clk_sys);
    chk("show_gone", 32'h0, 32'(mirror_show));
    $display("test still done");
    report_and_stop();
  end
  // Watchdog far beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("MISMATCH watchdog exp done got hang");
    report_and_stop();
  end
endmodule : vps_top_tb_top
bind vps_top vps_top_props i_vps_top_props (.clk_sys, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .fetch_valid, .fetch_req, .fetch_ready, .mirror_show, .illum_en, .irq);
